//--- hw/mrp_fifo.sv
// Read data FIFO with a registered output stage
`timescale 1ns/1ns
module mrp_fifo
	import mrp_pkg::*;
#(
	parameter int W     = LANE_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	mrp_stream_if.fifo s
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
	logic [AW:0]   count, next_count;
	logic          out_valid, next_out_valid;
	logic [W-1:0]  out_data, next_out_data;
	logic          push, pop;

	//------------------------------------------------------------------
	// Pointer and output stage
	//------------------------------------------------------------------
	// Ready is honest: storage full means the source stalls
	assign s.wr_ready = (count != (AW+1)'(DEPTH));
	assign push       = s.wr_valid && s.wr_ready;
	assign pop        = (count != '0) && (!out_valid || s.rd_ready);
	assign s.rd_valid = out_valid;
	assign s.rd_data  = out_data;

	// Next pointer, count and output values
	always_comb begin
		next_wptr      = push ? wptr + 1'b1 : wptr;
		next_rptr      = pop ? rptr + 1'b1 : rptr;
		next_count     = count + (AW+1)'(push) - (AW+1)'(pop);
		next_out_data  = pop ? mem[rptr] : out_data;
		next_out_valid = pop ? 1'b1 : (out_valid && !s.rd_ready);
	end

	// Register stage
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wptr      <= '0;
			rptr      <= '0;
			count     <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wptr      <= next_wptr;
			rptr      <= next_rptr;
			count     <= next_count;
			out_valid <= next_out_valid;
			out_data  <= next_out_data;
		end
	end

	// Storage needs no reset
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wptr] <= s.wr_data;
		end
	end
endmodule : mrp_fifo

//--- hw/mrp_mode_regs.sv
// Second and third mode registers, refresh rate, termination and pattern readout
`timescale 1ns/1ns
module mrp_mode_regs
	import mrp_pkg::*;
#(
	parameter int W = LANE_W
) (
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic         cmd_valid,
	input  wire mrp_cmd_t     cmd_code,
	input  wire logic [2:0]   cmd_bank,
	input  wire logic [13:0]  cmd_addr,
	output logic              cmd_ready,
	input  wire logic [3:0]   additive_latency,
	input  wire logic         nominal_term_en,
	input  wire logic         write_leveling,
	input  wire logic         chop_fixed,
	input  wire logic         chop_otf_en,
	input  wire logic         all_lanes,
	input  wire logic         case_hot,
	input  wire logic [W-1:0] array_rdata,
	input  wire logic         array_rvalid,
	output logic              array_read_req,
	output logic              array_write_req,
	output logic [3:0]        write_column_latency,
	output logic [4:0]        total_write_latency,
	output logic              self_refresh_double,
	output logic [1:0]        term_code,
	output logic              calib_active,
	output logic [W-1:0]      dq_data,
	output logic              dq_valid,
	input  wire logic         dq_ready
);
	typedef enum {
		GEN_IDLE,
		GEN_BURST
	} mrp_gen_t;

	mrp_stream_if #(.W(W)) strm ();

	logic         fire, is_read, mrs2, mrs3, chop;
	logic         auto_temp_refresh, next_atr;
	logic         forced_double_refresh, next_fdr;
	logic [1:0]   write_termination, next_wrt;
	logic [2:0]   mode_reg_three, next_mr3;
	logic [3:0]   next_cwl;
	logic [4:0]   next_twl;
	logic         next_double, next_cal;
	logic         next_rd_req, next_wr_req;
	logic         hot_meta, hot_sync;
	logic [4:0]   wr_wait, next_wr_wait;
	logic [2:0]   wr_hold, next_wr_hold;
	logic         wr_window;
	logic [1:0]   next_term;
	mrp_gen_t     gen_state, next_gen_state;
	logic [2:0]   gen_pos, next_gen_pos;
	logic [3:0]   gen_left, next_gen_left;
	logic         gen_bit;
	logic [W-1:0] gen_data;
	logic         next_cmd_ready;

	//------------------------------------------------------------------
	// Command decode
	//------------------------------------------------------------------
	// Only same-clock controller logic drives the command port
	assign fire    = cmd_valid && cmd_ready;
	assign is_read = (cmd_code == CMD_READ) || (cmd_code == CMD_READ_AP);
	assign mrs2    = fire && (cmd_code == CMD_MRS) && (cmd_bank == BANK_MR2);
	assign mrs3    = fire && (cmd_code == CMD_MRS) && (cmd_bank == BANK_MR3);
	// Chop when fixed, or on the fly with the chop address bit low
	assign chop    = chop_fixed || (chop_otf_en && !cmd_addr[ADDR_CHOP]);

	//------------------------------------------------------------------
	// Mode register storage
	//------------------------------------------------------------------
	// Reserved bits are dropped; fields hold until rewritten or reset
	always_comb begin
		next_cwl = write_column_latency;
		next_atr = auto_temp_refresh;
		next_fdr = forced_double_refresh;
		next_wrt = write_termination;
		next_mr3 = mode_reg_three;
		if (mrs2) begin
			next_cwl = CWL_BASE + {1'b0, cmd_addr[CWL_LSB +: 3]};
			next_atr = cmd_addr[ATR_BIT];
			next_fdr = cmd_addr[FDR_BIT];
			next_wrt = cmd_addr[WRT_LSB +: 2];
		end
		if (mrs3) begin
			next_mr3 = cmd_addr[2:0];
		end
	end

	// Mode register flops, reset also leaves pattern mode
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			write_column_latency  <= CWL_BASE;
			auto_temp_refresh     <= 1'b0;
			forced_double_refresh <= 1'b0;
			write_termination     <= WRT_RST;
			mode_reg_three        <= MR3_RST;
		end else begin
			write_column_latency  <= next_cwl;
			auto_temp_refresh     <= next_atr;
			forced_double_refresh <= next_fdr;
			write_termination     <= next_wrt;
			mode_reg_three        <= next_mr3;
		end
	end

	//------------------------------------------------------------------
	// Latency and self refresh rate
	//------------------------------------------------------------------
	// Case temperature flag is asynchronous; two stages before use
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hot_meta <= 1'b0;
			hot_sync <= 1'b0;
		end else begin
			hot_meta <= case_hot;
			hot_sync <= hot_meta;
		end
	end

	// Forced double wins if software breaks the exclusive setting
	always_comb begin
		next_twl    = {1'b0, write_column_latency} + {1'b0, additive_latency};
		next_double = forced_double_refresh
			|| (auto_temp_refresh && hot_sync);
		next_cal    = mode_reg_three[CAL_EN_BIT];
	end

	// Status flops
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			total_write_latency <= '0;
			self_refresh_double <= 1'b0;
			calib_active        <= 1'b0;
		end else begin
			total_write_latency <= next_twl;
			self_refresh_double <= next_double;
			calib_active        <= next_cal;
		end
	end

	//------------------------------------------------------------------
	// Array requests and write termination window
	//------------------------------------------------------------------
	// Pattern mode blocks array access; writes there are dropped
	always_comb begin
		next_rd_req  = fire && is_read && !mode_reg_three[CAL_EN_BIT];
		next_wr_req  = fire && (cmd_code == CMD_WRITE)
			&& !mode_reg_three[CAL_EN_BIT];
		next_wr_wait = (wr_wait != '0) ? wr_wait - 1'b1 : wr_wait;
		next_wr_hold = (wr_wait == '0 && wr_hold != '0) ? wr_hold - 1'b1 : wr_hold;
		if (next_wr_req) begin
			next_wr_wait = total_write_latency;
			next_wr_hold = chop ? WCLK_CHOP : WCLK_FULL;
		end
	end

	// Window covers the data clocks of the latest write burst
	assign wr_window = (wr_wait == '0) && (wr_hold != '0);

	// Termination choice; leveling suppresses the write value
	always_comb begin
		next_term = nominal_term_en ? TERM_NOM : TERM_HIGHZ;
		if (wr_window && write_termination != 2'h0 && !write_leveling) begin
			next_term = TERM_WR;
		end
	end

	// Request and termination flops
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			array_read_req  <= 1'b0;
			array_write_req <= 1'b0;
			wr_wait         <= '0;
			wr_hold         <= '0;
			term_code       <= TERM_HIGHZ;
		end else begin
			array_read_req  <= next_rd_req;
			array_write_req <= next_wr_req;
			wr_wait         <= next_wr_wait;
			wr_hold         <= next_wr_hold;
			term_code       <= next_term;
		end
	end

	//------------------------------------------------------------------
	// Calibration burst generator
	//------------------------------------------------------------------
	// Reserved selects return zeros so the controller never hangs
	assign gen_bit = (mode_reg_three[CAL_SEL_LSB +: 2] == CAL_SEL_PAT)
		&& CAL_WORD[gen_pos];

	// Primary lane carries the bit; others low unless all lanes
	generate
		for (genvar i = 0; i < W; i++) begin : g_lane
			if (i == 0) begin : g_prime
				assign gen_data[i] = gen_bit;
			end else begin : g_other
				assign gen_data[i] = all_lanes && gen_bit;
			end
		end
	endgenerate

	// Next state; only address bit 2 picks the start position
	always_comb begin
		next_gen_state = gen_state;
		next_gen_pos   = gen_pos;
		next_gen_left  = gen_left;
		case (gen_state)
			GEN_IDLE: begin
				if (fire && is_read && mode_reg_three[CAL_EN_BIT]) begin
					next_gen_state = GEN_BURST;
					next_gen_pos   = chop ? {cmd_addr[ADDR_NIBBLE], 2'b00} : 3'h0;
					next_gen_left  = chop ? BEATS_CHOP : BEATS_FULL;
				end
			end
			GEN_BURST: begin
				if (strm.wr_ready) begin
					next_gen_pos  = gen_pos + 1'b1;
					next_gen_left = gen_left - 1'b1;
					if (gen_left == 4'h1) begin
						next_gen_state = GEN_IDLE;
					end
				end
			end
			default: begin
				next_gen_state = GEN_IDLE;
			end
		endcase
		// Ready drops while a burst runs or the FIFO is full
		next_cmd_ready = (next_gen_state == GEN_IDLE) && strm.wr_ready;
	end

	// Generator flops
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			gen_state <= GEN_IDLE;
			gen_pos   <= '0;
			gen_left  <= '0;
			cmd_ready <= 1'b0;
		end else begin
			gen_state <= next_gen_state;
			gen_pos   <= next_gen_pos;
			gen_left  <= next_gen_left;
			cmd_ready <= next_cmd_ready;
		end
	end

	//------------------------------------------------------------------
	// Read data FIFO
	//------------------------------------------------------------------
	// Array data has no back-pressure; it is lost if the FIFO is full
	assign strm.wr_valid = (gen_state == GEN_BURST) || array_rvalid;
	assign strm.wr_data  = (gen_state == GEN_BURST) ? gen_data : array_rdata;
	assign strm.rd_ready = dq_ready;
	assign dq_data       = strm.rd_data;
	assign dq_valid      = strm.rd_valid;

	mrp_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.s       (strm.fifo)
	);

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_cal_read;
		fire && is_read && mode_reg_three[CAL_EN_BIT] && gen_state == GEN_IDLE;
	endsequence

	sequence s_burst_start(logic [2:0] p);
		(gen_state == GEN_BURST) && (gen_pos == p);
	endsequence

	property p_cwl_load;
		mrs2 |=> write_column_latency == CWL_BASE + {1'b0, $past(cmd_addr[5:3])};
	endproperty
	a_cwl_load: assert property (p_cwl_load)
		else $error("write column latency not loaded");

	property p_total;
		($stable(write_column_latency) && $stable(additive_latency)) [*2]
			|-> total_write_latency == {1'b0, write_column_latency} + {1'b0, additive_latency};
	endproperty
	a_total: assert property (p_total)
		else $error("total write latency wrong");

	property p_auto;
		auto_temp_refresh && hot_sync |=> self_refresh_double;
	endproperty
	a_auto: assert property (p_auto)
		else $error("auto refresh did not double");

	property p_normal;
		!auto_temp_refresh && !forced_double_refresh |=> !self_refresh_double;
	endproperty
	a_normal: assert property (p_normal)
		else $error("refresh rate not 1x");

	property p_forced;
		forced_double_refresh |=> self_refresh_double;
	endproperty
	a_forced: assert property (p_forced)
		else $error("forced double refresh ignored");

	property p_level;
		write_leveling |=> term_code != TERM_WR;
	endproperty
	a_level: assert property (p_level)
		else $error("write termination during leveling");

	property p_highz;
		!nominal_term_en && !wr_window |=> term_code == TERM_HIGHZ;
	endproperty
	a_highz: assert property (p_highz)
		else $error("nominal off but not high impedance");

	property p_array;
		fire && is_read && !mode_reg_three[CAL_EN_BIT] |=> array_read_req;
	endproperty
	a_array: assert property (p_array)
		else $error("array read not issued");

	property p_redirect;
		s_cal_read |=> !array_read_req ##0 gen_state == GEN_BURST;
	endproperty
	a_redirect: assert property (p_redirect)
		else $error("pattern read reached array");

	property p_chop_hi;
		s_cal_read ##0 chop && cmd_addr[ADDR_NIBBLE] |=> s_burst_start(3'h4);
	endproperty
	a_chop_hi: assert property (p_chop_hi)
		else $error("chopped burst upper half wrong");

	property p_pattern;
		gen_state == GEN_BURST && mode_reg_three[1:0] == CAL_SEL_PAT
			|-> gen_data[0] == gen_pos[0];
	endproperty
	a_pattern: assert property (p_pattern)
		else $error("pattern bit wrong");

	property p_lane;
		gen_state == GEN_BURST && !all_lanes |-> gen_data[W-1:1] == '0;
	endproperty
	a_lane: assert property (p_lane)
		else $error("secondary lanes not low");

	property p_keep;
		!mrs3 |=> $stable(mode_reg_three);
	endproperty
	a_keep: assert property (p_keep)
		else $error("third register changed unasked");

	property p_reset;
		disable iff (1'b0) sys_rst |=> !calib_active && gen_state == GEN_IDLE;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset did not leave pattern mode");
endmodule : mrp_mode_regs

//--- hw/mrp_pkg.sv
// Constants, field layouts and types for the mode register and pattern readout block
//------------------------------------------------------------------------------
// Overview of operation
// - Write column latency from second register bits 5:3
// - Total write latency is column plus additive
// - Auto refresh bit doubles rate when hot
// - Both refresh bits clear gives 1x rate
// - Forced double bit always gives 2x rate
// - Nonzero write termination field enables dynamic switching
// - Write termination only during write burst window
// - Nominal and write termination are independent
// - No write termination during write leveling
// - Third register kept until rewritten or reset
// - Pattern disabled: select ignored, array access
// - Pattern enabled: reads return calibration data
// - Reset still works in pattern mode
// - Pattern on primary lane or all lanes
// - Full or chopped bursts, fixed or on fly
// - Only address bit 2, and bit 12 when chop is on fly, matter for reads
// - Chopped burst: bit 2 picks upper half
// - First burst position carries word bit 0
// - Pattern alternates starting with zero
// - Bank 010 selects second, 011 third register
//------------------------------------------------------------------------------
package mrp_pkg;

	// Mode register selection by bank bits
	localparam logic [2:0] BANK_MR2      = 3'h2;
	localparam logic [2:0] BANK_MR3      = 3'h3;

	// Second mode register field positions
	localparam int         CWL_LSB       = 3;
	localparam int         ATR_BIT       = 6;
	localparam int         FDR_BIT       = 7;
	localparam int         WRT_LSB       = 9;
	localparam logic [3:0] CWL_BASE      = 4'h5;

	// Third mode register field positions
	localparam int         CAL_EN_BIT    = 2;
	localparam int         CAL_SEL_LSB   = 0;
	localparam logic [1:0] CAL_SEL_PAT   = 2'h0;

	// Read address bits used in pattern mode
	localparam int         ADDR_NIBBLE   = 2;
	localparam int         ADDR_CHOP     = 12;

	// Predefined calibration word, position n is bit n
	localparam logic [7:0] CAL_WORD      = 8'hAA;

	// Burst sizes in beats and in write clocks
	localparam logic [3:0] BEATS_FULL    = 4'h8;
	localparam logic [3:0] BEATS_CHOP    = 4'h4;
	localparam logic [2:0] WCLK_FULL     = 3'h4;
	localparam logic [2:0] WCLK_CHOP     = 3'h2;

	// Termination state codes
	localparam logic [1:0] TERM_HIGHZ    = 2'h0;
	localparam logic [1:0] TERM_NOM      = 2'h1;
	localparam logic [1:0] TERM_WR       = 2'h2;

	// Reset values
	localparam logic [1:0] WRT_RST       = 2'h0;
	localparam logic [2:0] MR3_RST       = 3'h0;

	// Data path sizes
	localparam int         LANE_W        = 8;
	localparam int         FIFO_DEPTH    = 16;

	// Commands seen on the command port
	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_MRS,
		CMD_READ,
		CMD_READ_AP,
		CMD_WRITE,
		CMD_OTHER
	} mrp_cmd_t;

endpackage : mrp_pkg

//--- hw/mrp_stream_if.sv
// Valid/ready stream between the readout logic and its FIFO
`timescale 1ns/1ns
interface mrp_stream_if #(parameter int W = 8);
	logic         wr_valid;
	logic         wr_ready;
	logic [W-1:0] wr_data;
	logic         rd_valid;
	logic         rd_ready;
	logic [W-1:0] rd_data;

	modport fifo (input wr_valid, input wr_data, output wr_ready,
		output rd_valid, output rd_data, input rd_ready);
	modport user (output wr_valid, output wr_data, input wr_ready,
		input rd_valid, input rd_data, output rd_ready);
endinterface : mrp_stream_if

//--- tb/mrp_ctrl_model.sv
// Behavioural memory controller that issues commands to the mode register block
`timescale 1ns/1ns
module mrp_ctrl_model
	import mrp_pkg::*;
#(
	parameter int MODE_GAP = 4
) (
	input  wire logic  ref_clk,
	input  wire logic  cmd_ready,
	output logic       cmd_valid,
	output mrp_cmd_t   cmd_code,
	output logic [2:0] cmd_bank,
	output logic [13:0] cmd_addr
);
	logic pat_on;   // Pattern mode as this controller believes it
	bit   last_ok;  // Outcome of the latest request

	// Idle bus at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_code  = CMD_NOP;
		cmd_bank  = 3'h0;
		cmd_addr  = 14'h0000;
		pat_on    = 1'b0;
		last_ok   = 1'b0;
	end

	//--------------------------------------------------------------------------
	// Command issue
	//--------------------------------------------------------------------------
	// Hold the request until an edge that sees ready high, or give up
	task automatic send(input mrp_cmd_t c, input logic [2:0] b, input logic [13:0] a,
		input int lim);
		int n;
		n = 0;
		last_ok = 1'b0;
		if (pat_on && c != CMD_READ && c != CMD_READ_AP && c != CMD_MRS)
			return;
		cmd_valid = 1'b1;
		cmd_code  = c;
		cmd_bank  = b;
		cmd_addr  = a;
		while (cmd_ready !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		last_ok = (cmd_ready === 1'b1);
		if (last_ok) begin
			@(posedge ref_clk);
			#1;
		end
		cmd_valid = 1'b0;
		cmd_code  = CMD_NOP;
		cmd_bank  = ~b;  // Released lines must not keep the last value
		cmd_addr  = ~a;
		repeat (MODE_GAP) @(posedge ref_clk);
		#1;
	endtask : send

	// Second register; never both refresh modes at once, reserved bits zero
	task automatic mrs2(input logic [2:0] code, input logic atr, input logic fdr,
		input logic [1:0] wrt);
		if (atr && fdr)
			fdr = 1'b0;
		send(CMD_MRS, 3'h2, {3'h0, wrt, 1'b0, fdr, atr, code, 3'h0}, 100);
	endtask : mrs2

	// Third register; banks assumed precharged by the gap after every command
	task automatic mrs3(input logic en, input logic [1:0] sel);
		send(CMD_MRS, 3'h3, {11'h000, en, sel}, 100);
		pat_on = en;
	endtask : mrs3

	// Read with the low two address bits forced to zero
	task automatic read(input logic [13:0] a, input int lim);
		send(CMD_READ, 3'h0, {a[13:2], 2'h0}, lim);
	endtask : read
endmodule : mrp_ctrl_model

//--- tb/sdram_mode_regs_pattern_readout_bench.sv
// Self-checking bench for the mode register and pattern readout block
`timescale 1ns/1ns
module sdram_mode_regs_pattern_readout_bench
	import mrp_pkg::*;
;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid, cmd_ready, nominal_term_en, write_leveling, chop_fixed, chop_otf_en;
	logic all_lanes, case_hot, array_rvalid, array_read_req, array_write_req;
	logic self_refresh_double, calib_active, dq_valid, dq_ready;
	mrp_cmd_t    cmd_code;
	logic [2:0]  cmd_bank;
	logic [13:0] cmd_addr;
	logic [3:0]  additive_latency, write_column_latency;
	logic [4:0]  total_write_latency;
	logic [1:0]  term_code;
	logic [7:0]  array_rdata, dq_data;
	logic [7:0]  beats[$];
	logic [31:0] xs = 32'h00000004;
	logic [7:0]  arr_val;
	int n_fail = 0, samples_checked = 0, cycles = 0, wr_cnt, rd_cnt, tw_cnt;
	localparam int CYCLE_LIMIT = 20000;

	always #5 ref_clk = ~ref_clk;

	mrp_ctrl_model ctl (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr));

	mrp_mode_regs dut (
		.ref_clk              (ref_clk),
		.sys_rst              (sys_rst),
		.cmd_valid            (cmd_valid),
		.cmd_code             (cmd_code),
		.cmd_bank             (cmd_bank),
		.cmd_addr             (cmd_addr),
		.cmd_ready            (cmd_ready),
		.additive_latency     (additive_latency),
		.nominal_term_en      (nominal_term_en),
		.write_leveling       (write_leveling),
		.chop_fixed           (chop_fixed),
		.chop_otf_en          (chop_otf_en),
		.all_lanes            (all_lanes),
		.case_hot             (case_hot),
		.array_rdata          (array_rdata),
		.array_rvalid         (array_rvalid),
		.array_read_req       (array_read_req),
		.array_write_req      (array_write_req),
		.write_column_latency (write_column_latency),
		.total_write_latency  (total_write_latency),
		.self_refresh_double  (self_refresh_double),
		.term_code            (term_code),
		.calib_active         (calib_active),
		.dq_data              (dq_data),
		.dq_valid             (dq_valid),
		.dq_ready             (dq_ready)
	);

	//--------------------------------------------------------------------------
	// Helpers
	//--------------------------------------------------------------------------
	// Repeatable random source
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		t = t ^ (t << 5);
		return t;
	endfunction : xorshift

	// Model clears forced double when both are asked, so auto wins
	function automatic logic exp_double(input logic atr, input logic fdr, input logic hot);
		return (atr && hot) || (fdr && !atr);
	endfunction : exp_double

	// Beat at a burst position; reserved select gives zeros
	function automatic logic [7:0] exp_beat(input int pos, input logic [1:0] sel,
		input logic all);
		logic b;
		b = (sel == CAL_SEL_PAT) && CAL_WORD[pos % 8];
		return all ? {8{b}} : {7'h00, b};
	endfunction : exp_beat

	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check_val

	task automatic check_beats(input int first, input int n, input logic [1:0] sel,
		input logic all);
		logic [7:0] e;
		for (int k = 0; k < n && k < beats.size(); k++) begin
			e = exp_beat(first + k, sel, all);
			samples_checked++;
			if (beats[k] !== e) begin
				n_fail++;
				$display("[FAIL] beat %0d expected %h seen %h", k, e, beats[k]);
			end
		end
	endtask : check_beats

	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop

	//--------------------------------------------------------------------------
	// Monitors and far-side array
	//--------------------------------------------------------------------------
	// Outputs read at the edge see values the design also saw there
	always @(posedge ref_clk) begin
		cycles++;
		if (term_code == TERM_WR) begin
			tw_cnt++;
		end
		if (array_write_req) begin
			wr_cnt++;
		end
		if (array_read_req) begin
			rd_cnt++;
		end
		if (!sys_rst && dq_valid && dq_ready) begin
			beats.push_back(dq_data);
		end
		array_rvalid <= array_read_req;
		#1;
		dq_ready = (cycles % 3) != 2;
	end

	//--------------------------------------------------------------------------
	// Scenarios
	//--------------------------------------------------------------------------
	// One pattern read with the given burst controls
	task automatic run_cal(input logic [1:0] sel, input logic cf, input logic otf,
		input logic [13:0] a, input int first, input int n);
		ctl.mrs3(1'b1, sel);
		chop_fixed = cf;
		chop_otf_en = otf;
		xs = xorshift(xs);
		all_lanes = xs[0];
		beats.delete();
		rd_cnt = 0;
		ctl.read(a, 100);
		repeat (40) @(posedge ref_clk);
		#1;
		check_val("cal active", 1, calib_active);
		check_val("cal array req", 0, rd_cnt);
		check_val("beat count", n, beats.size());
		check_beats(first, n, sel, all_lanes);
		$display("test pattern first %0d beats %0d done", first, n);
	endtask : run_cal

	task automatic run_tests();
		logic [2:0] code;
		logic       atr;
		logic       fdr;
		logic [1:0] wrt;
		xs = xorshift(xs);
		additive_latency = xs[3:0];
		repeat (16) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check_val("cwl reset", CWL_BASE, write_column_latency);
		check_val("twl reset", CWL_BASE + additive_latency, total_write_latency);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			xs = xorshift(xs);
			code = xs[2:0];
			atr = xs[3] || (i == 0);
			fdr = xs[4] || (i == 0);
			wrt = (i == 1) ? 2'h1 : xs[6:5];
			case_hot = xs[7];
			write_leveling = xs[8] && (i != 1);
			nominal_term_en = xs[9];
			ctl.mrs2(code, atr, fdr, wrt);
			check_val("cwl", CWL_BASE + code, write_column_latency);
			check_val("twl", CWL_BASE + code + additive_latency, total_write_latency);
			check_val("double", exp_double(atr, fdr, case_hot), self_refresh_double);
			tw_cnt = 0;
			wr_cnt = 0;
			ctl.send(CMD_WRITE, 3'h0, 14'h0000, 100);
			repeat (40) @(posedge ref_clk);
			#1;
			check_val("write req", 1, wr_cnt);
			check_val("write term", (wrt != 2'h0 && !write_leveling) ? WCLK_FULL : 0, tw_cnt);
			check_val("nominal", nominal_term_en ? TERM_NOM : TERM_HIGHZ, term_code);
			$display("test mode two %0d done", i);
		end
		xs = xorshift(xs);
		arr_val = xs[7:0];
		array_rdata = arr_val;
		beats.delete();
		rd_cnt = 0;
		ctl.read(14'h0004, 100);
		repeat (20) @(posedge ref_clk);
		#1;
		check_val("array req", 1, rd_cnt);
		check_val("array beats", 1, beats.size());
		check_val("array data", arr_val, beats[0]);
		$display("test array read done");
		run_cal(2'h0, 1'b0, 1'b0, 14'h0000, 0, 8);
		run_cal(2'h0, 1'b1, 1'b0, 14'h0004, 4, 4);
		run_cal(2'h0, 1'b0, 1'b1, 14'h0000, 0, 4);
		run_cal(2'h1, 1'b0, 1'b0, 14'h1000, 0, 8);
		sys_rst = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		ctl.pat_on = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		check_val("cal after reset", 0, calib_active);
		check_val("cwl after reset", CWL_BASE, write_column_latency);
		rd_cnt = 0;
		ctl.read(14'h0000, 100);
		repeat (20) @(posedge ref_clk);
		#1;
		check_val("array req after reset", 1, rd_cnt);
		$display("test mid-run reset done");
	endtask : run_tests

	// Main thread, raced against the cycle ceiling
	initial begin
		array_rvalid = 1'b0;
		array_rdata = 8'h00;
		dq_ready = 1'b1;
		nominal_term_en = 1'b0;
		write_leveling = 1'b0;
		chop_fixed = 1'b0;
		chop_otf_en = 1'b0;
		all_lanes = 1'b0;
		case_hot = 1'b0;
		additive_latency = 4'h0;
		fork
			run_tests();
			begin
				wait (cycles >= CYCLE_LIMIT);
				n_fail++;
				$display("[FAIL] cycle ceiling expected %0d seen %0d", CYCLE_LIMIT, cycles);
			end
		join_any
		report_and_stop();
	end
endmodule : sdram_mode_regs_pattern_readout_bench
